// ===== pkg/dsp_consts.svh
`ifndef DSP_CONSTS_SVH
`define DSP_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_ACCA_LO   8'h08
`define OFF_ACCA_HI   8'h0C
`define OFF_ACCB_LO   8'h10
`define OFF_ACCB_HI   8'h14

// ****************************************
// Control fields
// ****************************************
`define CTRL_W        6
`define CTRL_RESET    6'h00
`define CTRL_CLIP_LO  0
`define CTRL_CLIP_HI  1
`define CTRL_WIDE     2
`define CTRL_FRAC     3
`define CTRL_TRAP_A   4
`define CTRL_TRAP_B   5

// ****************************************
// Status fields
// ****************************************
`define ST_GUARD_A    0
`define ST_GUARD_B    1
`define ST_CLIP_A     2
`define ST_CLIP_B     3
`define ST_ANY_GUARD  4
`define ST_ANY_CLIP   5

// ****************************************
// Datapath widths and limits
// ****************************************
`define ACC_W         40
`define GUARD_LO      32
`define WORD_SIGN     31
`define PROD_W        33
`define ACC_RESET     40'h00_0000_0000
`define MAX32         40'h00_7FFF_FFFF
`define MIN32         40'hFF_8000_0000
`define MAX40         40'h7F_FFFF_FFFF
`define MIN40         40'h80_0000_0000

`endif

// ===== pkg/dsp_pkg.sv
package dsp_pkg;

  // ****************************************
  // Operation codes from the core
  // ****************************************
  typedef enum logic [2:0] {
    op_mac  = 3'h0,
    op_msc  = 3'h1,
    op_load = 3'h3,
    op_add  = 3'h2,
    op_mul  = 3'h6
  } op_type;

endpackage

// ===== src/mul_scaler.sv
module mul_scaler #(
  parameter int unsigned IN_W = 16
) (
  input  wire logic [IN_W-1:0] x_word,
  input  wire logic [IN_W-1:0] y_word,
  input  wire logic            x_signed,
  input  wire logic            y_signed,
  input  wire logic            frac_mode,
  output logic      [2*IN_W:0] product
);

  // ****************************************
  // Extension into the extra input bit
  // ****************************************
  wire logic [IN_W:0]     x_ext;
  wire logic [IN_W:0]     y_ext;
  wire logic [2*IN_W+1:0] full;

  assign x_ext = {x_signed & x_word[IN_W-1], x_word}; // [RULE_02] [RULE_03]
  assign y_ext = {y_signed & y_word[IN_W-1], y_word}; // [RULE_02] [RULE_03]
  assign full  = $signed(x_ext) * $signed(y_ext);     // [RULE_01] [RULE_05]

  // ****************************************
  // Scaler: fractional drops the extra sign bit
  // ****************************************
  assign product = frac_mode ? {full[2*IN_W-1:0], 1'h0} // [RULE_06] [RULE_22]
                             : full[2*IN_W:0];          // [RULE_01]

endmodule

// ===== src/dsp_mac_datapath.sv
// Behaviour
// RULE_01 - 17x17 multiplier, signed or unsigned, scaler picks 1.31 or integer.
// RULE_02 - Unsigned operand gets zero in the extra input bit.
// RULE_03 - Signed operand gets its top bit copied into the extra bit.
// RULE_04 - 33-bit multiplier output is sign-extended to 40 bits.
// RULE_05 - Integer mode treats data as two's complement, top bit is sign.
// RULE_06 - Fractional mode: radix after sign, 16x16 gives a 1.31 product. Product instruction stays integer here.
// RULE_07 - Same multiplier serves signed, unsigned and mixed integer multiply.
// RULE_08 - Product instruction: byte operands give 16 bits, words give 32.
// RULE_09 - 40-bit adder picks accumulator A or B as source and destination.
// RULE_10 - Add and load may scale incoming data through a barrel shifter.
// RULE_11 - Adder has optional forced-zero input and true or inverted data.
// RULE_12 - Add uses carry high with true data; subtract uses borrow low. Add here feeds carry_in 0.
// RULE_13 - Overflow out of bit 39 is catastrophic, sign lost.
// RULE_14 - Guard overflow when bits 32 to 39 are not all equal.
// RULE_15 - Saturation decided from result, overflows, enables and width bit.
// RULE_16 - Clipped flag set on bit-31 or bit-39 saturation of that acc.
// RULE_17 - Combined flags are OR of both guard and both clipped flags.
// RULE_18 - Guard flags refresh on every adder operation.
// RULE_19 - Overflow and saturation status is latched and readable.
// RULE_20 - Trap when guard flag becomes set with its trap enable set.
// RULE_21 - Clamp to 32-bit limits, or 40-bit limits in wide mode.
// RULE_22 - Fractional scaler shifts product left one bit.
`include "dsp_consts.svh"

module dsp_mac_datapath #(
  parameter int unsigned DATA_W = 16
) (
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                op_valid,
  input  wire dsp_pkg::op_type     op_code,
  input  wire logic                acc_select,
  input  wire logic [DATA_W-1:0]   operand_x,
  input  wire logic [DATA_W-1:0]   operand_y,
  input  wire logic                x_signed,
  input  wire logic                y_signed,
  input  wire logic                byte_size,
  input  wire logic [3:0]          shift_amount,
  input  wire logic [DATA_W-1:0]   load_data,
  output logic      [2*DATA_W-1:0] product_result,
  output logic                     product_valid,
  output logic      [`ACC_W-1:0]   acc_a,
  output logic      [`ACC_W-1:0]   acc_b,
  output logic                     acc_a_guard_overflow,
  output logic                     acc_b_guard_overflow,
  output logic                     acc_a_clipped_flag,
  output logic                     acc_b_clipped_flag,
  output logic                     any_guard_overflow,
  output logic                     any_clipped_flag,
  output logic                     arith_trap
);
  import dsp_pkg::*;

  localparam int unsigned HALF = DATA_W / 2;

  // ****************************************
  // Control register fields
  // ****************************************
  logic [`CTRL_W-1:0] ctrl;
  wire  logic [1:0]   acc_clip_enables;
  wire  logic         clip_width_select;
  wire  logic         frac_mode;
  wire  logic [1:0]   trap_enables;
  wire  logic         acc_a_overflow_trap_enable;
  wire  logic         acc_b_overflow_trap_enable;

  assign acc_clip_enables = ctrl[`CTRL_CLIP_HI:`CTRL_CLIP_LO];
  assign clip_width_select = ctrl[`CTRL_WIDE];
  assign frac_mode = ctrl[`CTRL_FRAC];
  assign acc_a_overflow_trap_enable = ctrl[`CTRL_TRAP_A];
  assign acc_b_overflow_trap_enable = ctrl[`CTRL_TRAP_B];
  assign trap_enables = {acc_b_overflow_trap_enable,
                         acc_a_overflow_trap_enable};

  // ****************************************
  // Operation decode
  // ****************************************
  wire logic is_mul;
  wire logic is_sub;
  wire logic force_zero;
  wire logic use_data;
  wire logic acc_op;
  wire logic mul_op;

  assign is_mul     = op_code == op_mul;
  assign is_sub     = op_code == op_msc;
  assign force_zero = op_code == op_load;
  assign use_data   = (op_code == op_add) || (op_code == op_load);
  assign acc_op     = op_valid && !is_mul;
  assign mul_op     = op_valid && is_mul;

  // ****************************************
  // Multiplier and scaler
  // ****************************************
  wire logic [DATA_W-1:0]   x_word;
  wire logic [DATA_W-1:0]   y_word;
  wire logic                mul_frac;
  wire logic [2*DATA_W:0]   product33;
  wire logic [`ACC_W-1:0]   product40;
  wire logic [2*DATA_W-1:0] next_product;

  // Byte operands of the product instruction are extended to a word before the multiply
  assign x_word = (is_mul && byte_size) ?
    {{HALF{x_signed & operand_x[HALF-1]}}, operand_x[HALF-1:0]} :
    operand_x;                                      // [RULE_07]
  assign y_word = (is_mul && byte_size) ?
    {{HALF{y_signed & operand_y[HALF-1]}}, operand_y[HALF-1:0]} :
    operand_y;                                      // [RULE_07]
  assign mul_frac = frac_mode && !is_mul;

  mul_scaler #(
    .IN_W      (DATA_W)
  ) u_mul (
    .x_word    (x_word),
    .y_word    (y_word),
    .x_signed  (x_signed),
    .y_signed  (y_signed),
    .frac_mode (mul_frac),
    .product   (product33)
  );

  assign product40 = {{(`ACC_W-2*DATA_W-1){product33[2*DATA_W]}},
                      product33};                   // [RULE_04]
  assign next_product = byte_size ?
    {{DATA_W{1'h0}}, product33[DATA_W-1:0]} :
    product33[2*DATA_W-1:0];                        // [RULE_08]

  // ****************************************
  // Barrel shifter for add and load
  // ****************************************
  wire logic [`ACC_W-1:0] load40;
  wire logic [3:0]        shift_mag;
  wire logic [`ACC_W-1:0] scaled;

  assign load40 = {{(`ACC_W-2*DATA_W){load_data[DATA_W-1]}},
                   load_data, {DATA_W{1'h0}}};
  assign shift_mag = shift_amount[3] ? 4'(~shift_amount + 4'h1)
                                     : shift_amount;
  // Negative amount shifts left, positive shifts right arithmetic
  assign scaled = shift_amount[3] ? (load40 << shift_mag)
                : `ACC_W'($signed(load40) >>> shift_mag); // [RULE_10]

  // ****************************************
  // Adder and subtracter
  // ****************************************
  logic [`ACC_W-1:0]    acc [2];
  wire  logic [`ACC_W-1:0] acc_src;
  wire  logic [`ACC_W-1:0] side_a;
  wire  logic [`ACC_W-1:0] data_in;
  wire  logic [`ACC_W-1:0] side_b;
  wire  logic              carry_in;
  wire  logic [`ACC_W:0]   sum;
  wire  logic [`ACC_W-1:0] raw;

  assign acc_src  = acc[acc_select];                // [RULE_09]
  assign side_a   = force_zero ? `ACC_RESET : acc_src; // [RULE_11]
  assign data_in  = use_data ? scaled : product40;
  assign side_b   = is_sub ? ~data_in : data_in;    // [RULE_11] [RULE_12]
  // Borrow is active low, so subtract feeds a one
  assign carry_in = is_sub;                         // [RULE_12]
  assign sum = {1'h0, side_a} + {1'h0, side_b}
             + {{`ACC_W{1'h0}}, carry_in};
  assign raw = sum[`ACC_W-1:0];

  // ****************************************
  // Overflow detection and saturation
  // ****************************************
  wire logic              ov39;
  wire logic              guard_ov;
  wire logic              ov31;
  wire logic              clip_on;
  wire logic              true_neg;
  wire logic              sat_now;
  wire logic [`ACC_W-1:0] clip_val;
  wire logic [`ACC_W-1:0] next_acc;

  assign ov39 = (side_a[`ACC_W-1] == side_b[`ACC_W-1])
             && (raw[`ACC_W-1] != side_a[`ACC_W-1]); // [RULE_13]
  assign guard_ov = !((&raw[`ACC_W-1:`GUARD_LO])
                   || !(|raw[`ACC_W-1:`GUARD_LO])); // [RULE_14]
  assign ov31 = !((&raw[`ACC_W-1:`WORD_SIGN])
               || !(|raw[`ACC_W-1:`WORD_SIGN]));
  assign clip_on  = acc_clip_enables[acc_select];
  assign true_neg = ov39 ? !raw[`ACC_W-1] : raw[`ACC_W-1];
  assign sat_now  = clip_on && (clip_width_select ? ov39
                                                  : (ov39 || ov31)); // [RULE_15]
  assign clip_val = clip_width_select ?
    (true_neg ? `MIN40 : `MAX40) :
    (true_neg ? `MIN32 : `MAX32);                   // [RULE_21]
  assign next_acc = sat_now ? clip_val : raw;       // [RULE_15]

  // ****************************************
  // Register bus decode
  // ****************************************
  wire logic        setup;
  wire logic        access;
  wire logic        hit_ctrl;
  wire logic        hit_status;
  wire logic        mapped;
  wire logic        wr_ctrl;
  wire logic        wr_status;
  wire logic [31:0] status_word;
  wire logic [31:0] read_word;
  logic      [1:0]  guard;
  logic      [1:0]  clipped;

  assign setup      = psel && !penable;
  assign access     = psel && penable;
  assign hit_ctrl   = paddr == `OFF_CTRL;
  assign hit_status = paddr == `OFF_STATUS;
  assign mapped = hit_ctrl || hit_status
               || (paddr == `OFF_ACCA_LO) || (paddr == `OFF_ACCA_HI)
               || (paddr == `OFF_ACCB_LO) || (paddr == `OFF_ACCB_HI);
  assign wr_ctrl    = access && pwrite && hit_ctrl;
  assign wr_status  = access && pwrite && hit_status;
  assign pready     = 1'h1;
  assign pslverr    = access && !mapped;

  assign status_word = {26'h000_0000, any_clipped_flag, any_guard_overflow,
                        clipped, guard};            // [RULE_19]
  assign read_word =
    hit_ctrl                   ? {26'h000_0000, ctrl} :
    hit_status                 ? status_word :
    (paddr == `OFF_ACCA_LO)    ? acc[0][`GUARD_LO-1:0] :
    (paddr == `OFF_ACCA_HI)    ? {24'h00_0000, acc[0][`ACC_W-1:`GUARD_LO]} :
    (paddr == `OFF_ACCB_LO)    ? acc[1][`GUARD_LO-1:0] :
    (paddr == `OFF_ACCB_HI)    ? {24'h00_0000, acc[1][`ACC_W-1:`GUARD_LO]} :
                                 32'h0000_0000;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= read_word;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[`CTRL_W-1:0];
    end
  end

  // ****************************************
  // Per-accumulator state
  // ****************************************
  logic [1:0] trap_hit;

  for (genvar i = 0; i < 2; i++) begin : g_acc
    wire logic sel;
    wire logic clr;
    assign sel = acc_op && (acc_select == 1'(i));
    assign clr = wr_status && pwdata[`ST_CLIP_A + i];
    // Guard flag tracks the latest operation; trap on a rising flag
    assign trap_hit[i] = sel && guard_ov && !guard[i]
                      && trap_enables[i];           // [RULE_20]

    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        acc[i]     <= `ACC_RESET;
        guard[i]   <= 1'h0;
        clipped[i] <= 1'h0;
      end else begin
        if (sel) begin
          acc[i]   <= next_acc;                     // [RULE_09]
          guard[i] <= guard_ov;                     // [RULE_18]
        end
        // Set wins over a software clear in the same cycle
        if (sel && sat_now) begin
          clipped[i] <= 1'h1;                       // [RULE_16]
        end else if (clr) begin
          clipped[i] <= 1'h0;
        end
      end
    end
  end

  assign acc_a = acc[0];
  assign acc_b = acc[1];
  assign acc_a_guard_overflow = guard[0];
  assign acc_b_guard_overflow = guard[1];
  assign acc_a_clipped_flag   = clipped[0];
  assign acc_b_clipped_flag   = clipped[1];
  assign any_guard_overflow   = |guard;             // [RULE_17]
  assign any_clipped_flag     = |clipped;           // [RULE_17]

  // ****************************************
  // Product output and trap pulse
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      product_result <= '0;
      product_valid  <= 1'h0;
      arith_trap     <= 1'h0;
    end else begin
      if (mul_op) begin
        product_result <= next_product;             // [RULE_08]
      end
      product_valid <= mul_op;
      arith_trap    <= |trap_hit;                   // [RULE_20]
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence mul_issue;
    op_valid && op_code == op_mul;
  endsequence

  sequence word_mul;
    mul_issue ##0 !byte_size;
  endsequence

  sequence acc_a_op;
    op_valid && op_code != op_mul && !acc_select;
  endsequence

  product_pulse_a: assert property ( // [RULE_07]
    mul_issue |=> product_valid ##1 (product_valid == $past(mul_op)))
    else $error("product valid pulse misplaced");

  signed_word_a: assert property ( // [RULE_03] [RULE_05]
    word_mul ##0 (x_signed && y_signed) |=>
      $signed(product_result) ==
      $signed($past(operand_x)) * $signed($past(operand_y)))
    else $error("signed word product wrong");

  unsigned_word_a: assert property ( // [RULE_02]
    word_mul ##0 (!x_signed && !y_signed) |=>
      product_result == $past(operand_x) * $past(operand_y))
    else $error("unsigned word product wrong");

  byte_product_a: assert property ( // [RULE_08]
    mul_issue ##0 (byte_size && !x_signed && !y_signed) |=>
      product_result == 32'($past(operand_x[HALF-1:0]))
                      * 32'($past(operand_y[HALF-1:0])))
    else $error("byte product wrong");

  load_zero_a: assert property ( // [RULE_11] [RULE_10]
    acc_a_op ##0 (op_code == op_load && shift_amount == 4'h0
                  && !acc_clip_enables[0]) |=>
      acc_a == $past(load40))
    else $error("load did not replace accumulator");

  guard_track_a: assert property ( // [RULE_14] [RULE_18]
    acc_a_op ##0 !acc_clip_enables[0] |=>
      acc_a_guard_overflow ==
      !((&acc_a[`ACC_W-1:`GUARD_LO]) || !(|acc_a[`ACC_W-1:`GUARD_LO])))
    else $error("guard flag does not match accumulator");

  clamp_range_a: assert property ( // [RULE_21] [RULE_15]
    acc_a_op ##0 (acc_clip_enables[0] && !clip_width_select) |=>
      (&acc_a[`ACC_W-1:`WORD_SIGN]) || !(|acc_a[`ACC_W-1:`WORD_SIGN]))
    else $error("accumulator left 32-bit range");

  clip_sticky_a: assert property ( // [RULE_19] [RULE_16]
    acc_a_clipped_flag && !(wr_status && pwdata[`ST_CLIP_A]) |=>
      acc_a_clipped_flag)
    else $error("clipped flag lost without clear");

  combined_flags_a: assert property ( // [RULE_17]
    any_guard_overflow == (acc_a_guard_overflow || acc_b_guard_overflow)
    && any_clipped_flag == (acc_a_clipped_flag || acc_b_clipped_flag))
    else $error("combined flags wrong");

  trap_raise_a: assert property ( // [RULE_20]
    acc_a_op ##0 (guard_ov && !guard[0] && acc_a_overflow_trap_enable)
    |=> arith_trap ##1 !$past(arith_trap) || !arith_trap || $past(op_valid))
    else $error("trap not raised on new guard overflow");

  sign_loss_clamp_a: assert property ( // [RULE_13] [RULE_21]
    acc_a_op ##0 (ov39 && acc_clip_enables[0] && clip_width_select) |=>
      acc_a == `MAX40 || acc_a == `MIN40)
    else $error("bit 39 overflow not clamped");

endmodule

// ===== bench/core_issue_model.sv
module core_issue_model (
  input  wire logic       clock,
  output logic            op_valid,
  output dsp_pkg::op_type op_code,
  output logic            acc_select,
  output logic [15:0]     operand_x,
  output logic [15:0]     operand_y,
  output logic            x_signed,
  output logic            y_signed,
  output logic            byte_size,
  output logic [3:0]      shift_amount,
  output logic [15:0]     load_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Idle levels
  // ****************************************
  initial begin
    op_valid = 1'h0;
    op_code = dsp_pkg::op_mac;
    acc_select = 1'h0;
    operand_x = 16'h0;
    operand_y = 16'h0;
    x_signed = 1'h0;
    y_signed = 1'h0;
    byte_size = 1'h0;
    shift_amount = 4'h0;
    load_data = 16'h0;
  end

  // ****************************************
  // One operation, taken at the next edge
  // ****************************************
  task automatic issue(input dsp_pkg::op_type c, input logic s,
                       input logic [15:0] x, input logic [15:0] y,
                       input logic [15:0] ld, input logic [2:0] sg,
                       input logic [3:0] sh);
    op_valid <= 1'h1;
    op_code <= c;
    acc_select <= s;
    operand_x <= x;
    operand_y <= y;
    {x_signed, y_signed, byte_size} <= sg;
    shift_amount <= sh;
    load_data <= ld;
    @(posedge clock);
    op_valid <= 1'h0;
    // Released operands never keep the stale value
    operand_x <= ~x;
    operand_y <= ~y;
    load_data <= ~ld;
    shift_amount <= ~sh;
  endtask
endmodule

// ===== bench/dsp_multiply_accumulate_datapath_tb.sv
`include "dsp_consts.svh"

module dsp_multiply_accumulate_datapath_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dsp_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic        clock = 1'h0;
  logic        nrst = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        op_valid;
  op_type      op_code;
  logic        acc_select;
  logic [15:0] operand_x;
  logic [15:0] operand_y;
  logic        x_signed;
  logic        y_signed;
  logic        byte_size;
  logic [3:0]  shift_amount;
  logic [15:0] load_data;
  logic [31:0] product_result;
  logic        product_valid;
  logic [39:0] acc_a;
  logic [39:0] acc_b;
  logic        acc_a_guard_overflow;
  logic        acc_b_guard_overflow;
  logic        acc_a_clipped_flag;
  logic        acc_b_clipped_flag;
  logic        any_guard_overflow;
  logic        any_clipped_flag;
  logic        arith_trap;
  int          num_errors = 0;
  int          num_checks = 0;

  always #50 clock = ~clock;

  dsp_mac_datapath i_dsp_mac_datapath (
    .clock, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .op_valid, .op_code, .acc_select, .operand_x,
    .operand_y, .x_signed, .y_signed, .byte_size, .shift_amount,
    .load_data, .product_result, .product_valid, .acc_a, .acc_b,
    .acc_a_guard_overflow, .acc_b_guard_overflow, .acc_a_clipped_flag,
    .acc_b_clipped_flag, .any_guard_overflow, .any_clipped_flag,
    .arith_trap
  );

  core_issue_model i_core_issue_model (
    .clock, .op_valid, .op_code, .acc_select, .operand_x, .operand_y,
    .x_signed, .y_signed, .byte_size, .shift_amount, .load_data
  );

  // ****************************************
  // Cases: ctrl, op, acc, x, y, sign/byte, shift, data, result, flags
  // ****************************************
  typedef struct packed {
    logic [5:0]  ctrl;
    op_type      code;
    logic        sel;
    logic [15:0] x;
    logic [15:0] y;
    logic [2:0]  sg;
    logic [3:0]  sh;
    logic [15:0] ld;
    logic [39:0] res;
    logic [2:0]  flg;
  } row_type;

  row_type rows [24] = '{
    '{6'h00,op_mul,1'h0,16'hFFFF,16'hFFFF,3'h6,4'h0,16'h0,40'h1,3'h0},
    '{6'h00,op_mul,1'h0,16'hFFFF,16'hFFFF,3'h0,4'h0,16'h0,40'hFFFE0001,3'h0},
    '{6'h00,op_mul,1'h0,16'hFFFF,16'hFFFF,3'h4,4'h0,16'h0,40'hFFFF0001,3'h0},
    '{6'h00,op_mul,1'h0,16'h8000,16'h8000,3'h6,4'h0,16'h0,40'h40000000,3'h0},
    '{6'h00,op_mul,1'h0,16'h00FF,16'h00FF,3'h1,4'h0,16'h0,40'hFE01,3'h0},
    '{6'h00,op_mul,1'h0,16'h0080,16'h0002,3'h7,4'h0,16'h0,40'hFF00,3'h0},
    '{6'h08,op_mul,1'h0,16'h4000,16'h4000,3'h6,4'h0,16'h0,40'h10000000,3'h0},
    '{6'h00,op_load,1'h0,16'h0,16'h0,3'h0,4'h0,16'h4000,40'h40000000,3'h0},
    '{6'h00,op_add,1'h0,16'h0,16'h0,3'h0,4'h0,16'h4000,40'h80000000,3'h0},
    '{6'h01,op_add,1'h0,16'h0,16'h0,3'h0,4'h0,16'h4000,40'h7FFFFFFF,3'h2},
    '{6'h01,op_load,1'h0,16'h0,16'h0,3'h0,4'h0,16'h8000,40'hFF80000000,3'h2},
    '{6'h01,op_add,1'h0,16'h0,16'h0,3'h0,4'h0,16'h8000,40'hFF80000000,3'h2},
    '{6'h20,op_load,1'h1,16'h0,16'h0,3'h0,4'h8,16'h7FFF,40'h7FFF000000,3'h5},
    '{6'h20,op_add,1'h1,16'h0,16'h0,3'h0,4'h0,16'h0,40'h7FFF000000,3'h4},
    '{6'h00,op_load,1'h1,16'h0,16'h0,3'h0,4'h0,16'h0,40'h0,3'h0},
    '{6'h08,op_mac,1'h1,16'h4000,16'h4000,3'h6,4'h0,16'h0,40'h20000000,3'h0},
    '{6'h00,op_mac,1'h1,16'h4000,16'h4000,3'h6,4'h0,16'h0,40'h30000000,3'h0},
    '{6'h00,op_msc,1'h1,16'h4000,16'h4000,3'h6,4'h0,16'h0,40'h20000000,3'h0},
    '{6'h00,op_mac,1'h1,16'hFFFF,16'h0002,3'h4,4'h0,16'h0,40'h1FFFFFFE,3'h0},
    '{6'h06,op_load,1'h1,16'h0,16'h0,3'h0,4'h8,16'h7FFF,40'h7FFF000000,3'h4},
    '{6'h06,op_add,1'h1,16'h0,16'h0,3'h0,4'h8,16'h7FFF,40'h7FFFFFFFFF,3'h2},
    '{6'h00,op_load,1'h0,16'h0,16'h0,3'h0,4'h1,16'h8000,40'hFFC0000000,3'h2},
    '{6'h15,op_load,1'h0,16'h0,16'h0,3'h0,4'h8,16'h7FFF,40'h7FFF000000,3'h7},
    '{6'h15,op_add,1'h0,16'h0,16'h0,3'h0,4'h8,16'h7FFF,40'h7FFFFFFFFF,3'h2}
  };

  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report();
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      $display("CHECK FAILED at %0t: no ready", $time);
      num_errors++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    row_type     r;
    logic [31:0] rd;
    logic        er;
    logic [39:0] ea [2];
    logic [1:0]  eg;
    logic [1:0]  ec;
    ea[0] = 40'h0;
    ea[1] = 40'h0;
    eg = 2'h0;
    ec = 2'h0;
    repeat (5) @(posedge clock);
    chk(acc_a | acc_b, 40'h0);
    chk(40'({pready, pslverr, arith_trap, product_valid, any_clipped_flag,
             any_guard_overflow}), 40'h20);
    nrst <= 1'h1;
    apb(1'h0, `OFF_STATUS, 32'h0, rd, er);
    chk(40'(rd), 40'h0);
    apb(1'h1, `OFF_CTRL, 32'hFFFFFFFF, rd, er);
    apb(1'h0, `OFF_CTRL, 32'h0, rd, er);
    chk(40'(rd), 40'h3F);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'h1, `OFF_CTRL, {26'h0, r.ctrl}, rd, er);
      i_core_issue_model.issue(r.code, r.sel, r.x, r.y, r.ld, r.sg, r.sh);
      #1;
      if (r.code == op_mul) begin
        chk(40'(product_result), r.res);
      end else begin
        ea[r.sel] = r.res;
        eg[r.sel] = r.flg[2];
        ec[r.sel] = r.flg[1];
      end
      chk(40'(product_valid), 40'(r.code == op_mul));
      chk(acc_a, ea[0]);
      chk(acc_b, ea[1]);
      chk(40'({any_clipped_flag, any_guard_overflow, acc_b_clipped_flag,
               acc_a_clipped_flag, acc_b_guard_overflow,
               acc_a_guard_overflow}),
          40'({|ec, |eg, ec, eg}));
      chk(40'(arith_trap), 40'(r.flg[0]));
    end
    apb(1'h0, `OFF_STATUS, 32'h0, rd, er);
    chk(40'({rd, er}), 40'({|ec, |eg, ec, eg, 1'h0}));
    apb(1'h1, `OFF_STATUS, 32'h4, rd, er);
    ec[0] = 1'h0;
    apb(1'h0, `OFF_STATUS, 32'h0, rd, er);
    chk(40'(rd), 40'({|ec, |eg, ec, eg}));
    apb(1'h1, `OFF_ACCA_LO, 32'h12345678, rd, er);
    apb(1'h0, `OFF_ACCA_LO, 32'h0, rd, er);
    chk(40'(rd), 40'(ea[0][31:0]));
    apb(1'h0, `OFF_ACCA_HI, 32'h0, rd, er);
    chk(40'(rd), 40'(ea[0][39:32]));
    apb(1'h0, `OFF_ACCB_LO, 32'h0, rd, er);
    chk(40'(rd), 40'(ea[1][31:0]));
    apb(1'h0, `OFF_ACCB_HI, 32'h0, rd, er);
    chk(40'(rd), 40'(ea[1][39:32]));
    apb(1'h0, 8'h18, 32'h0, rd, er);
    chk(40'({rd, er}), 40'h1);
    @(posedge clock);
    nrst <= 1'h0;
    @(posedge clock);
    #1;
    chk(acc_b, 40'h0);
    chk(40'(any_clipped_flag), 40'h0);
    @(posedge clock);
    nrst <= 1'h1;
    apb(1'h0, `OFF_CTRL, 32'h0, rd, er);
    chk(40'(rd), 40'h0);
    final_report();
  end
endmodule
